// *** hw/scc_pkg.sv ***
// constants and types shared by the serial channel core
package scc_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] SCC_ADDR_DATA   = 4'h0;
  localparam logic [3:0] SCC_ADDR_CTRL   = 4'h1;
  localparam logic [3:0] SCC_ADDR_MODE0  = 4'h2;
  localparam logic [3:0] SCC_ADDR_MODE2  = 4'h3;
  localparam logic [3:0] SCC_ADDR_BAUD   = 4'h4;
  localparam logic [3:0] SCC_ADDR_FRAC   = 4'h5;
  localparam logic [3:0] SCC_ADDR_STATUS = 4'h6;
  // serial_control field positions
  localparam int SCC_CTRL_DIR   = 0;
  localparam int SCC_CTRL_EDGE  = 1;
  localparam int SCC_CTRL_NINTH = 2;
  // serial_mode_0 field positions
  localparam int SCC_M0_SRC_LO  = 0;
  localparam int SCC_M0_UART    = 2;
  localparam int SCC_M0_NINE    = 3;
  localparam int SCC_M0_WAKE    = 4;
  localparam int SCC_M0_HSHK    = 5;
  localparam int SCC_M0_TB8     = 6;
  // serial_mode_2 field positions
  localparam int SCC_M2_DBUF    = 0;
  localparam int SCC_M2_FULL    = 1;
  localparam int SCC_M2_OVR     = 2;
  // baud_gen_control field positions
  localparam int SCC_BG_DIV_LO  = 0;
  localparam int SCC_BG_FRAC_EN = 4;
  // reset values
  localparam logic [7:0] SCC_CTRL_RST  = 8'h00;
  localparam logic [7:0] SCC_MODE0_RST = 8'h04;
  localparam logic [7:0] SCC_MODE2_RST = 8'h00;
  localparam logic [7:0] SCC_BAUD_RST  = 8'h00;
  localparam logic [7:0] SCC_FRAC_RST  = 8'h00;
  // timing counts
  localparam int SCC_OVS          = 16;
  localparam int SCC_TMR_HALVES   = 2;
  localparam logic [3:0] SCC_SMP_A = 4'h6;
  localparam logic [3:0] SCC_SMP_B = 4'h7;
  localparam logic [3:0] SCC_SMP_C = 4'h8;
  localparam logic [3:0] SCC_OVS_LAST = 4'hf;
  // oversampling sources
  localparam logic [1:0] SCC_SRC_BRG  = 2'h0;
  localparam logic [1:0] SCC_SRC_HALF = 2'h1;
  localparam logic [1:0] SCC_SRC_TMR  = 2'h2;
  localparam logic [1:0] SCC_SRC_EXT  = 2'h3;
  typedef enum logic [1:0] {SCC_TX_IDLE, SCC_TX_WAIT, SCC_TX_SEND} scc_tx_e;
endpackage

// *** hw/scc_baud_gen.sv ***
// baud rate generator with integer and fractional division
`timescale 1ns/1ps
module scc_baud_gen
  import scc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       tick_in,
  input  wire logic [3:0] integer_divisor,
  input  wire logic [3:0] fraction_value,
  input  wire logic       fractional_div_enable,
  output logic            tick_out
);
  logic [4:0] cnt_q;
  logic [4:0] acc_q;
  logic [4:0] limit;
  logic       extra;
  logic [4:0] acc_sum;

  always_comb
  begin
    // zero divisor means sixteen
    limit   = (integer_divisor == 4'h0) ? 5'd16 : {1'b0, integer_divisor};
    // (16-k)/16 remainder accumulates; one extra input tick per overflow
    acc_sum = acc_q + 5'(5'd16 - {1'b0, fraction_value});
    extra   = fractional_div_enable && fraction_value != 4'h0 && acc_sum >= 5'd16;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q    <= 5'd0;
      acc_q    <= 5'd0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (tick_in)
      begin
        if (cnt_q + 5'd1 >= limit + {4'd0, extra} || cnt_q >= limit)
        begin
          cnt_q    <= 5'd0;
          tick_out <= 1'b1;
          if (fractional_div_enable)
            acc_q <= extra ? 5'(acc_sum - 5'd16) : acc_sum;
        end
        else
          cnt_q <= cnt_q + 5'd1;
      end
    end
  end
endmodule

// *** hw/scc_core.sv ***
// serial channel core: uart and clocked i/o transfer, receive double buffer
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module scc_core
  import scc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       prescaler_tick,
  input  wire logic       timer_trigger,
  input  wire logic       receive_pin,
  output logic            transmit_pin,
  input  wire logic       serial_clock_pin_i,
  output logic            serial_clock_pin_o,
  output logic            serial_clock_pin_oe,
  input  wire logic       clear_to_send_input,
  output logic            receive_interrupt,
  output logic            transmit_interrupt
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] serial_control_q;
  logic [7:0] serial_mode_0_q;
  logic [7:0] serial_mode_2_q;
  logic [7:0] baud_gen_control_q;
  logic [7:0] baud_fraction_reg_q;
  logic       full_q, ovr_q, rb8_q, shift_full_q;
  logic [7:0] hold_q, rx_sh_q;
  logic [7:0] tx_data_q;
  logic       tx_b8_q;
  logic       tx_pend_q;

  logic clock_direction, clock_edge_select, uart_mode, nine_bit, wakeup_enable;
  logic handshake_enable, double_buffer_enable;
  logic [1:0] oversample_source_select;
  assign clock_direction          = serial_control_q[SCC_CTRL_DIR];
  assign clock_edge_select        = serial_control_q[SCC_CTRL_EDGE];
  assign oversample_source_select = serial_mode_0_q[SCC_M0_SRC_LO +: 2];
  assign uart_mode                = serial_mode_0_q[SCC_M0_UART];
  assign nine_bit                 = serial_mode_0_q[SCC_M0_NINE];
  assign wakeup_enable            = serial_mode_0_q[SCC_M0_WAKE];
  assign handshake_enable         = serial_mode_0_q[SCC_M0_HSHK];
  assign double_buffer_enable     = serial_mode_2_q[SCC_M2_DBUF];

  logic wr_data, rd_data;
  assign wr_data = wr && addr == SCC_ADDR_DATA;
  assign rd_data = rd && addr == SCC_ADDR_DATA;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      serial_control_q    <= SCC_CTRL_RST;
      serial_mode_0_q     <= SCC_MODE0_RST;
      serial_mode_2_q     <= SCC_MODE2_RST;
      baud_gen_control_q  <= SCC_BAUD_RST;
      baud_fraction_reg_q <= SCC_FRAC_RST;
    end
    else if (wr)
    begin
      case (addr)
        SCC_ADDR_CTRL:  serial_control_q    <= wdata;
        SCC_ADDR_MODE0: serial_mode_0_q     <= wdata;
        SCC_ADDR_MODE2: serial_mode_2_q     <= wdata;
        SCC_ADDR_BAUD:  baud_gen_control_q  <= wdata;
        SCC_ADDR_FRAC:  baud_fraction_reg_q <= wdata;
        default:        ;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers and clock edges
  // ----------------------------------------
  logic [2:0] sck_q, rxp_q, cts_q;
  logic       sck_st_q, rx_st_q, cts_st_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sck_q    <= 3'h7;
      rxp_q    <= 3'h7;
      cts_q    <= 3'h0;
      sck_st_q <= 1'b1;
      rx_st_q  <= 1'b1;
      cts_st_q <= 1'b0;
    end
    else
    begin
      sck_q <= {sck_q[1:0], serial_clock_pin_i};
      rxp_q <= {rxp_q[1:0], receive_pin};
      cts_q <= {cts_q[1:0], clear_to_send_input};
      if (sck_q[1] == sck_q[2])
        sck_st_q <= sck_q[2];
      if (rxp_q[1] == rxp_q[2])
        rx_st_q <= rxp_q[2];
      if (cts_q[1] == cts_q[2])
        cts_st_q <= cts_q[2];
    end
  end
  logic sck_d_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
      sck_d_q <= 1'b1;
    else
      sck_d_q <= sck_st_q;
  end
  logic ext_rise, ext_fall, ext_edge;
  assign ext_rise = sck_st_q && !sck_d_q;
  assign ext_fall = !sck_st_q && sck_d_q;
  assign ext_edge = clock_edge_select ? ext_fall : ext_rise;

  // ----------------------------------------
  // clock sources
  // ----------------------------------------
  logic brg_tick, half_q, tmr_half_q, ovs_tick;
  scc_baud_gen u_brg (
    .mclk                  (mclk),
    .rst                   (rst),
    .tick_in               (prescaler_tick),
    .integer_divisor       (baud_gen_control_q[SCC_BG_DIV_LO +: 4]),
    .fraction_value        (baud_fraction_reg_q[3:0]),
    .fractional_div_enable (baud_gen_control_q[SCC_BG_FRAC_EN] && uart_mode),
    .tick_out              (brg_tick)
  );
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      half_q     <= 1'b0;
      tmr_half_q <= 1'b0;
    end
    else
    begin
      half_q <= !half_q;
      // trigger pulses pair up so the rate is compare x 2 x 16
      if (timer_trigger)
        tmr_half_q <= !tmr_half_q;
    end
  end
  always_comb
  begin
    case (oversample_source_select)
      SCC_SRC_BRG:  ovs_tick = brg_tick;
      SCC_SRC_HALF: ovs_tick = half_q;
      SCC_SRC_TMR:  ovs_tick = timer_trigger && tmr_half_q && uart_mode;
      SCC_SRC_EXT:  ovs_tick = ext_rise;
      default:      ovs_tick = 1'b0;
    endcase
  end

  // driven shift clock: generator output halved
  logic sclk_q, clk_run;
  logic io_out, io_rise, io_fall, io_tick;
  assign io_out = !uart_mode && !clock_direction;
  always_ff @(posedge mclk)
  begin
    if (rst)
      sclk_q <= 1'b1;
    else if (!io_out)
      sclk_q <= 1'b1;
    else if (brg_tick && (clk_run || !sclk_q))
      sclk_q <= !sclk_q;
  end
  assign io_fall = io_out && brg_tick && sclk_q && clk_run;
  assign io_rise = io_out && brg_tick && !sclk_q;
  assign serial_clock_pin_o  = sclk_q;
  assign serial_clock_pin_oe = io_out;
  // shift edge: rising of driven clock or chosen external edge
  assign io_tick = io_out ? io_rise : (!uart_mode && ext_edge);

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic [3:0] rx_cnt_q;
  logic [3:0] rx_bits_q;
  logic [2:0] vote_q;
  logic       rx_busy_q, rx_done;
  logic       maj;
  logic [3:0] frame_bits;
  assign frame_bits = nine_bit ? 4'd10 : 4'd9;
  assign maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx_st_q) | (vote_q[1] & rx_st_q);
  logic       frame_ninth;
  logic [7:0] frame_data;
  logic       rx_ninth_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_cnt_q   <= 4'h0;
      rx_bits_q  <= 4'h0;
      vote_q     <= 3'h0;
      rx_busy_q  <= 1'b0;
      rx_sh_q    <= 8'h00;
      rx_ninth_q <= 1'b0;
    end
    else if (uart_mode)
    begin
      if (ovs_tick)
      begin
        if (!rx_busy_q)
        begin
          rx_cnt_q <= 4'h0;
          if (!rx_st_q)
            rx_busy_q <= 1'b1; // candidate start edge
        end
        else
        begin
          rx_cnt_q <= rx_cnt_q + 4'h1;
          if (rx_cnt_q == SCC_SMP_A)
            vote_q[0] <= rx_st_q;
          if (rx_cnt_q == SCC_SMP_B)
            vote_q[1] <= rx_st_q;
          if (rx_cnt_q == SCC_SMP_C)
          begin
            if (rx_bits_q == 4'h0 && maj)
              rx_busy_q <= 1'b0; // false start rejected
            else if (rx_bits_q == frame_bits)
            begin
              rx_busy_q <= 1'b0;
              rx_bits_q <= 4'h0;
            end
            else
            begin
              rx_bits_q <= rx_bits_q + 4'h1;
              if (rx_bits_q != 4'h0)
              begin
                if (nine_bit && rx_bits_q == 4'd9)
                  rx_ninth_q <= maj;
                else
                  rx_sh_q <= {maj, rx_sh_q[7:1]};
              end
            end
          end
        end
      end
    end
    else
    begin
      rx_busy_q <= 1'b0;
      rx_cnt_q  <= 4'h0;
      if (io_tick && !(io_out && shift_full_q))
      begin
        rx_sh_q   <= {rx_st_q, rx_sh_q[7:1]};
        rx_bits_q <= (rx_bits_q == 4'd7) ? 4'h0 : rx_bits_q + 4'h1;
      end
    end
  end
  // stop-bit centre completes a uart frame; eighth shift an io frame
  assign rx_done = uart_mode ? (ovs_tick && rx_busy_q && rx_cnt_q == SCC_SMP_C
                                && rx_bits_q == frame_bits)
                             : (io_tick && !(io_out && shift_full_q) && rx_bits_q == 4'd7);
  assign frame_data  = uart_mode ? rx_sh_q : {rx_st_q, rx_sh_q[7:1]};
  assign frame_ninth = rx_ninth_q; // parity or data msb

  // ----------------------------------------
  // receive buffers and flags
  // ----------------------------------------
  logic single_io, move_up, rx_irq_ok;
  assign single_io = io_out && !double_buffer_enable;
  assign move_up   = io_out && double_buffer_enable && rd_data && shift_full_q;
  assign rx_irq_ok = !(uart_mode && nine_bit && wakeup_enable) || frame_ninth;
  logic [7:0] shift_keep_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      hold_q            <= 8'h00;
      rb8_q             <= 1'b0;
      full_q            <= 1'b0;
      ovr_q             <= 1'b0;
      shift_full_q      <= 1'b0;
      shift_keep_q      <= 8'h00;
      receive_interrupt <= 1'b0;
    end
    else
    begin
      receive_interrupt <= 1'b0;
      if (rd && addr == SCC_ADDR_MODE2)
        ovr_q <= 1'b0;
      if (rd_data)
        full_q <= 1'b0;
      if (single_io && rd_data)
        shift_full_q <= 1'b0; // restarts the clock
      if (move_up)
      begin
        hold_q            <= shift_keep_q;
        full_q            <= 1'b1;
        shift_full_q      <= 1'b0;
        receive_interrupt <= 1'b1;
      end
      if (rx_done)
      begin
        if (single_io)
        begin
          shift_keep_q      <= frame_data;
          shift_full_q      <= 1'b1;
          receive_interrupt <= 1'b1;
        end
        else if (io_out && full_q && !rd_data)
        begin
          shift_keep_q <= frame_data;
          shift_full_q <= 1'b1;
        end
        else if (full_q && !rd_data)
          ovr_q <= 1'b1; // shift data dropped, buffer kept
        else
        begin
          hold_q            <= frame_data;
          rb8_q             <= frame_ninth;
          full_q            <= 1'b1;
          receive_interrupt <= rx_irq_ok;
        end
      end
    end
  end
  assign clk_run = !shift_full_q;

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  logic [3:0] tx_cnt_q;
  logic       tx_bit_clk;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_left_q;
  scc_tx_e    tx_st_q;
  logic       cts_hold;
  assign cts_hold = handshake_enable && cts_st_q;
  assign tx_bit_clk = ovs_tick && tx_cnt_q == SCC_OVS_LAST;

  always_ff @(posedge mclk)
  begin
    if (rst)
      tx_cnt_q <= 4'h0;
    else if (ovs_tick)
      tx_cnt_q <= tx_cnt_q + 4'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_st_q            <= SCC_TX_IDLE;
      tx_sh_q            <= 11'h7ff;
      tx_left_q          <= 4'h0;
      tx_data_q          <= 8'h00;
      tx_b8_q            <= 1'b0;
      tx_pend_q          <= 1'b0;
      transmit_interrupt <= 1'b0;
      transmit_pin       <= 1'b1;
    end
    else
    begin
      transmit_interrupt <= 1'b0;
      if (wr_data)
      begin
        tx_data_q <= wdata; // kept while held off
        tx_b8_q   <= serial_mode_0_q[SCC_M0_TB8];
        tx_pend_q <= 1'b1;
      end
      case (tx_st_q)
        SCC_TX_IDLE:
        begin
          transmit_pin <= 1'b1;
          if (tx_pend_q)
            tx_st_q <= SCC_TX_WAIT;
        end
        SCC_TX_WAIT:
        begin
          if (uart_mode && tx_bit_clk && !cts_hold)
          begin
            transmit_pin <= 1'b0;
            tx_sh_q   <= nine_bit ? {2'b11, tx_b8_q, tx_data_q} : {3'b111, tx_data_q};
            tx_left_q <= nine_bit ? 4'd10 : 4'd9;
            tx_pend_q <= 1'b0;
            tx_st_q   <= SCC_TX_SEND;
          end
          else if (!uart_mode)
          begin
            tx_sh_q   <= {3'b111, tx_data_q};
            tx_left_q <= 4'd8;
            tx_pend_q <= 1'b0;
            tx_st_q   <= SCC_TX_SEND;
          end
        end
        SCC_TX_SEND:
        begin
          if (uart_mode ? tx_bit_clk : io_tick)
          begin
            if (tx_left_q == 4'h0)
            begin
              transmit_pin       <= 1'b1;
              transmit_interrupt <= 1'b1; // raised even when held off
              tx_st_q            <= SCC_TX_IDLE; // frame finished first
            end
            else
            begin
              transmit_pin <= tx_sh_q[0];
              tx_sh_q      <= {1'b1, tx_sh_q[10:1]};
              tx_left_q    <= tx_left_q - 4'h1;
            end
          end
        end
        default: tx_st_q <= SCC_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        SCC_ADDR_DATA:   rdata <= single_io ? shift_keep_q : hold_q;
        SCC_ADDR_CTRL:   rdata <= {serial_control_q[7:3], rb8_q, serial_control_q[1:0]};
        SCC_ADDR_MODE0:  rdata <= serial_mode_0_q;
        SCC_ADDR_MODE2:  rdata <= {serial_mode_2_q[7:3], ovr_q, full_q, serial_mode_2_q[0]};
        SCC_ADDR_BAUD:   rdata <= baud_gen_control_q;
        SCC_ADDR_FRAC:   rdata <= baud_fraction_reg_q;
        SCC_ADDR_STATUS: rdata <= {4'h0, shift_full_q, tx_pend_q, tx_st_q};
        default:         rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end
endmodule

// *** tb/scc_core_checker.sv ***
// assertion checker for the serial channel core ports
`timescale 1ns/1ps
module scc_core_checker
  import scc_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       prescaler_tick,
  input wire logic       timer_trigger,
  input wire logic       receive_pin,
  input wire logic       transmit_pin,
  input wire logic       serial_clock_pin_i,
  input wire logic       serial_clock_pin_o,
  input wire logic       serial_clock_pin_oe,
  input wire logic       clear_to_send_input,
  input wire logic       receive_interrupt,
  input wire logic       transmit_interrupt
);
  // ------------------------------
  // shadow registers and bit timer
  // ------------------------------
  logic [7:0] m0_q;
  logic [7:0] ctl_q;
  logic [7:0] run_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      m0_q  <= SCC_MODE0_RST;
      ctl_q <= SCC_CTRL_RST;
    end
    else if (wr && addr == SCC_ADDR_MODE0)
      m0_q <= wdata;
    else if (wr && addr == SCC_ADDR_CTRL)
      ctl_q <= wdata;
  end

  // cycles since the transmit line last changed
  always_ff @(posedge mclk)
  begin
    if (rst)
      run_q <= 8'hff;
    else if ($changed(transmit_pin))
      run_q <= 8'h00;
    else if (run_q != 8'hff)
      run_q <= run_q + 8'h01;
  end

  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_rdata_quiet: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero without a read");
  a_rx_irq_pulse: assert property (receive_interrupt |=> !receive_interrupt)
    else $error("receive interrupt longer than one cycle");
  a_tx_irq_pulse: assert property (transmit_interrupt |=> !transmit_interrupt)
    else $error("transmit interrupt longer than one cycle");
  a_reset_idle: assert property ($fell(rst) |-> transmit_pin && serial_clock_pin_o && !serial_clock_pin_oe
    && rdata == 8'h00 && !receive_interrupt && !transmit_interrupt)
    else $error("outputs not idle after reset");
  a_clock_enable: assert property (!wr && !$past(wr)
    |-> serial_clock_pin_oe == (!m0_q[SCC_M0_UART] && !ctl_q[SCC_CTRL_DIR]))
    else $error("clock enable does not follow mode");
  a_mode_readback: assert property (rd && addr == SCC_ADDR_MODE0 |=> rdata[6:0] == m0_q[6:0])
    else $error("mode register readback wrong");
  a_full_cleared: assert property ((rd && addr == SCC_ADDR_DATA) ##2 (rd && addr == SCC_ADDR_MODE2)
    |=> !rdata[SCC_M2_FULL])
    else $error("full flag not cleared by data read");
  a_tx_bit_width: assert property (m0_q[SCC_M0_UART] && $changed(transmit_pin) |-> run_q >= 8'h1f)
    else $error("transmit bit shorter than sixteen ticks");
endmodule

bind scc_core scc_core_checker scc_core_checker_inst (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .prescaler_tick(prescaler_tick), .timer_trigger(timer_trigger), .receive_pin(receive_pin),
  .transmit_pin(transmit_pin), .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe), .clear_to_send_input(clear_to_send_input),
  .receive_interrupt(receive_interrupt), .transmit_interrupt(transmit_interrupt)
);

// *** tb/scc_remote_dev.sv ***
// remote uart device model: frame sender, frame decoder, clear-to-send
`timescale 1ns/1ps
module scc_remote_dev
(
  input  wire logic mclk,
  output logic      rx_line,
  input  wire logic tx_line,
  output logic      cts_line
);
  int         bit_cyc = 32;
  logic       hold_off = 1'b0;
  logic [7:0] got_byte;
  int         got_cnt = 0;
  logic [8:0] rsh;

  initial rx_line = 1'b1;
  assign cts_line = hold_off;

  // start bit, data lsb first, optional ninth bit, one stop bit
  task automatic send(input logic [8:0] d, input logic nine);
    logic [10:0] fr;
    int          n;
    fr = nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    n  = nine ? 11 : 10;
    for (int i = 0; i < n; i++)
    begin
      @(posedge mclk);
      rx_line <= fr[i];
      repeat (bit_cyc - 1) @(posedge mclk);
    end
  endtask

  // decode frames at bit centres
  always
  begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++)
    begin
      rsh[i] = tx_line;
      repeat (bit_cyc) @(posedge mclk);
    end
    got_byte = rsh[8:1];
    got_cnt++;
  end
endmodule

// *** tb/tb_top.sv ***
// testbench for the serial channel core with a remote uart model
`timescale 1ns/1ps
module tb_top
  import scc_pkg::*;
;
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       tick = 1'b0;
  logic       ext_clk = 1'b1;
  logic       receive_pin;
  logic       transmit_pin;
  logic       sclk_o;
  logic       sclk_oe;
  logic       cts;
  logic       rx_irq;
  logic       tx_irq;
  wire        sclk_pin = sclk_oe ? sclk_o : ext_clk;
  int         err_total = 0;
  int         comparisons = 0;
  logic [7:0] v;
  logic       got;
  int         n0;
  logic [7:0] rst_exp [8] = '{8'h00, SCC_CTRL_RST, SCC_MODE0_RST, SCC_MODE2_RST,
                              SCC_BAUD_RST, SCC_FRAC_RST, 8'h00, 8'h00};
  logic [7:0] src_m0 [6] = '{8'h05, 8'h06, 8'h04, 8'h04, 8'h04, 8'h07};
  logic [7:0] src_bd [6] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h12, 8'h00};
  int         src_bc [6] = '{32, 64, 64, 512, 80, 64};

  scc_core scc_core_inst (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .prescaler_tick(tick), .timer_trigger(tick), .receive_pin(receive_pin), .transmit_pin(transmit_pin),
    .serial_clock_pin_i(sclk_pin), .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe(sclk_oe),
    .clear_to_send_input(cts), .receive_interrupt(rx_irq), .transmit_interrupt(tx_irq)
  );
  scc_remote_dev scc_remote_dev_inst (
    .mclk(mclk), .rx_line(receive_pin), .tx_line(transmit_pin), .cts_line(cts)
  );

  initial
  begin
    forever #10 mclk = ~mclk;
  end

  // tick pulse every second cycle for prescaler and timer
  always @(posedge mclk) tick <= ~tick;

  // external serial clock, period four cycles
  always @(posedge mclk)
    if (tick)
      ext_clk <= ~ext_clk;

  // -------------
  // bus and check
  // -------------
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_irq(input logic tx, input int lim, output logic g);
    g = 1'b0;
    repeat (lim)
    begin
      @(posedge mclk);
      #1;
      if ((tx ? tx_irq : rx_irq) === 1'b1)
      begin
        g = 1'b1;
        break;
      end
    end
  endtask

  task automatic rx_case(input logic [7:0] d, input logic [8:0] f, input int lim);
    fork
      scc_remote_dev_inst.send(f, 1'b0);
      wait_irq(1'b0, lim, got);
    join
    chk("rx irq", got, 1'b1);
    rd_reg(SCC_ADDR_MODE2, v);
    chk("full set", v[SCC_M2_FULL], 1'b1);
    rd_reg(SCC_ADDR_DATA, v);
    chk("rx data", v, d);
    rd_reg(SCC_ADDR_MODE2, v);
    chk("full clear", v[SCC_M2_FULL], 1'b0);
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // -----
  // tests
  // -----
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(4'(a), v);
      chk("reset value", v, rst_exp[a]);
    end
    $display("test reset done");
    wr_reg(SCC_ADDR_FRAC, 8'h08);
    for (int i = 0; i < 6; i++)
    begin
      wr_reg(SCC_ADDR_MODE0, src_m0[i]);
      wr_reg(SCC_ADDR_BAUD, src_bd[i]);
      scc_remote_dev_inst.bit_cyc = src_bc[i];
      rx_case(8'ha5 ^ 8'(i * 17), {1'b0, 8'ha5 ^ 8'(i * 17)}, src_bc[i] * 12);
    end
    $display("test sources done");
    scc_remote_dev_inst.bit_cyc = 32;
    wr_reg(SCC_ADDR_MODE0, 8'h05);
    scc_remote_dev_inst.send(9'h03e, 1'b0);
    scc_remote_dev_inst.send(9'h0c1, 1'b0);
    rd_reg(SCC_ADDR_MODE2, v);
    chk("overrun flags", v, 8'h06);
    rd_reg(SCC_ADDR_DATA, v);
    chk("overrun data", v, 8'h3e);
    $display("test overrun done");
    wr_reg(SCC_ADDR_MODE0, 8'h1d);
    fork
      scc_remote_dev_inst.send(9'h011, 1'b1);
      wait_irq(1'b0, 400, got);
    join
    chk("wake skip", got, 1'b0);
    rd_reg(SCC_ADDR_DATA, v);
    fork
      scc_remote_dev_inst.send(9'h122, 1'b1);
      wait_irq(1'b0, 400, got);
    join
    chk("wake irq", got, 1'b1);
    rd_reg(SCC_ADDR_CTRL, v);
    chk("ninth bit", v[SCC_CTRL_NINTH], 1'b1);
    rd_reg(SCC_ADDR_DATA, v);
    chk("wake data", v, 8'h22);
    $display("test wake done");
    wr_reg(SCC_ADDR_MODE0, 8'h25);
    wr_reg(SCC_ADDR_DATA, 8'h96);
    repeat (100) @(posedge mclk);
    scc_remote_dev_inst.hold_off <= 1'b1;
    wait_irq(1'b1, 500, got);
    chk("tx irq", got, 1'b1);
    chk("tx data", scc_remote_dev_inst.got_byte, 8'h96);
    n0 = scc_remote_dev_inst.got_cnt;
    wr_reg(SCC_ADDR_DATA, 8'hc3);
    repeat (600) @(posedge mclk);
    chk("held line", transmit_pin, 1'b1);
    chk("held count", scc_remote_dev_inst.got_cnt - n0, 0);
    scc_remote_dev_inst.hold_off <= 1'b0;
    wait_irq(1'b1, 800, got);
    chk("tx resume", scc_remote_dev_inst.got_byte, 8'hc3);
    $display("test transmit done");
    wr_reg(SCC_ADDR_BAUD, 8'h02);
    wr_reg(SCC_ADDR_MODE0, 8'h00);
    wait_irq(1'b0, 200, got);
    chk("io frame irq", got, 1'b1);
    repeat (2)
    begin
      repeat (3) @(posedge mclk);
      chk("io clock halt", sclk_o, 1'b1);
    end
    rd_reg(SCC_ADDR_DATA, v);
    chk("io data", v, 8'hff);
    wait_irq(1'b0, 200, got);
    chk("io restart", got, 1'b1);
    $display("test io done");
    end_sim();
  end

  initial
  begin
    repeat (40000) @(posedge mclk);
    err_total++;
    end_sim();
  end
endmodule
